//--- pkg/pwr_ctl_pkg.sv
// Register map, field layout and timing constants for power mode control
package pwr_ctl_pkg;

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_PGATE   = 8'h04;
  localparam logic [7:0] OFS_PDIV    = 8'h08;
  localparam logic [7:0] OFS_VMAP    = 8'h0c;
  localparam logic [7:0] OFS_PLL     = 8'h10;
  localparam logic [7:0] OFS_EXTMODE = 8'h14;
  localparam logic [7:0] OFS_EXTPOL  = 8'h18;
  localparam logic [7:0] OFS_EXTFLAG = 8'h1c;
  localparam logic [7:0] OFS_WAKEEN  = 8'h20;
  localparam logic [7:0] OFS_EXTSEL  = 8'h24;
  localparam logic [7:0] OFS_RTCSRC  = 8'h28;
  localparam logic [7:0] OFS_STATUS  = 8'h2c;

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int unsigned BIT_IDLE    = 0;
  localparam int unsigned BIT_PDOWN   = 1;
  localparam int unsigned BIT_PLL_EN  = 0;
  localparam int unsigned BIT_PLL_CON = 1;
  localparam int unsigned EXT_N       = 9;
  localparam int unsigned IRQ_N       = 4;
  localparam int unsigned PERIPH_N    = 16;
  localparam logic [1:0]  PDIV_FULL    = 2'h1;
  localparam logic [1:0]  PDIV_HALF    = 2'h2;
  localparam logic [1:0]  PDIV_QUARTER = 2'h0;
  localparam logic [1:0]  PDIV_RST     = PDIV_QUARTER;
  localparam logic [15:0] PGATE_RST    = 16'hffff;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned WAKE_TIME_US  = 100;
  localparam int unsigned WAKE_CYCLES   =
    (WAKE_TIME_US * (CLK_HZ / 1_000_000));

  // ****************************************************
  // Power states
  // ****************************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PDOWN = 2'b10,
    ST_WAKE  = 2'b11
  } pwr_state_t;

endpackage

//--- design/pclk_divider.sv
// Peripheral clock enable divider: full, half or quarter of cpu clock
`timescale 1ns/1ns
module pclk_divider
  import pwr_ctl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);

  logic [1:0] cnt_ff;
  logic [1:0] last_val;

  always_comb begin
    last_val = 2'h3;
    if (sel_in == PDIV_FULL) begin
      last_val = 2'h0;
    end else if (sel_in == PDIV_HALF) begin
      last_val = 2'h1;
    end
  end

  // Counter stops while the oscillator is gated
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff   <= 2'h0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      tick_out <= 1'b0;
    end else if (cnt_ff >= last_val) begin
      cnt_ff   <= 2'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_ff   <= cnt_ff + 2'h1;
      tick_out <= 1'b0;
    end
  end

endmodule

//--- design/wake_timer.sv
// Oscillator settle timer that holds off execution after power-down
`timescale 1ns/1ns
module wake_timer #(
  parameter int unsigned CYCLES = 2000
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  output logic      done_out
);

  logic [15:0] cnt_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff   <= 16'h0000;
      done_out <= 1'b0;
    end else if (start_in) begin
      cnt_ff   <= 16'h0000;
      done_out <= 1'b0;
    end else if (cnt_ff == CYCLES[15:0] - 16'h0001) begin
      done_out <= 1'b1;
    end else if (!done_out) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

endmodule

//--- design/power_mode_clock_control.sv
// Power mode, clock gating, wake-up and vector map control block
//
// Contract
// - Idle stops instruction execution until reset or interrupt.
// - Peripherals keep clocks in idle; their interrupts resume the cpu.
// - Idle gates clocks of cpu, memories and internal buses.
// - Power-down stops oscillator and gates every internal clock.
// - Power-down keeps all state and holds outputs at last level.
// - Power-down ends on reset or clockless wake interrupts.
// - External inputs, edge or level, combine into four interrupts.
// - Each external input individually enabled as power-down wake source.
// - Software maps vector region at zero to flash or ram.
// - Peripheral clock is cpu clock divided by one, two or four.
// - Peripheral divider resets to quarter rate.
// - Pll stays running in idle if it was running before.
// - Rtc on external 32 kHz source keeps counting in power-down.
// - Each peripheral clock can be switched off individually.
// - After reset pll is off and bypassed.
// - Every interrupt wake from power-down passes through oscillator settle timer; reset skips it.
`timescale 1ns/1ns
module power_mode_clock_control
  import pwr_ctl_pkg::*;
#(
  parameter int unsigned WAKE_CNT = WAKE_CYCLES
) (
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [7:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic      [31:0]         wb_dat_out,
  output logic                     wb_ack_out,
  input  wire logic [EXT_N-1:0]    ext_irq_in,
  input  wire logic                periph_irq_in,
  output logic                     cpu_clock_en_out,
  output logic                     mem_bus_clk_en_out,
  output logic                     osc_en_out,
  output logic                     pll_en_out,
  output logic                     pll_connect_out,
  output logic                     peripheral_bus_tick_out,
  output logic [PERIPH_N-1:0]      periph_clk_en_out,
  output logic                     rtc_ext_clk_out,
  output logic                     vec_map_ram_out,
  output logic [IRQ_N-1:0]         irq_out,
  output logic                     pin_hold_out
);

  // ****************************************************
  // Input synchroniser
  // ****************************************************
  logic [EXT_N-1:0] ext_meta_ff;
  logic [EXT_N-1:0] ext_sync_ff;
  logic [EXT_N-1:0] ext_last_ff;
  logic             pirq_meta_ff;
  logic             pirq_sync_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {ext_meta_ff, ext_sync_ff, ext_last_ff} <= '0;
      {pirq_meta_ff, pirq_sync_ff}            <= 2'b00;
    end else begin
      ext_meta_ff  <= ext_irq_in;
      ext_sync_ff  <= ext_meta_ff;
      ext_last_ff  <= ext_sync_ff;
      pirq_meta_ff <= periph_irq_in;
      pirq_sync_ff <= pirq_meta_ff;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  pwr_state_t        state_ff;
  logic [1:0]        mode_ff;
  logic [PERIPH_N-1:0] pgate_ff;
  logic [1:0]        pdiv_ff;
  logic              vmap_ff;
  logic [1:0]        pll_ff;
  logic [EXT_N-1:0]  extmode_ff;
  logic [EXT_N-1:0]  extpol_ff;
  logic [EXT_N-1:0]  extflag_ff;
  logic [EXT_N-1:0]  wakeen_ff;
  logic [2*EXT_N-1:0] extsel_ff;
  logic              rtcsrc_ff;
  logic              wake_done;

  logic              wr_stb;
  logic              rd_stb;
  logic [EXT_N-1:0]  ext_event;
  logic [IRQ_N-1:0]  nxt_irq;
  logic              any_irq;
  logic              pd_wake;

  function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
  assign rd_stb = wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out;

  // Level inputs are active while at the chosen polarity
  always_comb begin
    for (int i = 0; i < EXT_N; i++) begin
      ext_event[i] = extmode_ff[i] ?
        ((ext_sync_ff[i] ^ ~extpol_ff[i]) &
         ~(ext_last_ff[i] ^ ~extpol_ff[i])) :
        (ext_sync_ff[i] ^ ~extpol_ff[i]);
    end
  end

  // Each input routed to one of the four lines by its selector
  always_comb begin
    nxt_irq = '0;
    for (int i = 0; i < EXT_N; i++) begin
      if (extflag_ff[i]) begin
        nxt_irq[extsel_ff[2*i +: 2]] = 1'b1;
      end
    end
  end

  assign any_irq = (|nxt_irq) || pirq_sync_ff;
  // Wake: synchronised enabled event (level or edge) or pending enabled flag
  assign pd_wake = |((ext_event | extflag_ff) & wakeen_ff);

  // ****************************************************
  // Power state machine
  // ****************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_RUN;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (mode_ff[BIT_PDOWN]) begin
            state_ff <= ST_PDOWN;
          end else if (mode_ff[BIT_IDLE]) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE:  if (any_irq) state_ff <= ST_RUN;
        ST_PDOWN: if (pd_wake) state_ff <= ST_WAKE;
        ST_WAKE:  if (wake_done) state_ff <= ST_RUN;
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  wake_timer #(
    .CYCLES (WAKE_CNT)
  ) u_wake (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (state_ff == ST_PDOWN),
    .done_out (wake_done)
  );

  // ****************************************************
  // Mode register, cleared by hardware on wake
  // ****************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_ff <= 2'h0;
    end else if ((state_ff == ST_IDLE && any_irq) ||
                 (state_ff == ST_WAKE && wake_done)) begin
      mode_ff <= 2'h0;
    end else if (wr_stb && wb_adr_in == OFS_MODE && wb_sel_in[0] &&
                 state_ff == ST_RUN) begin
      mode_ff <= wb_dat_in[1:0];
    end
  end

  // ****************************************************
  // Configuration registers
  // ****************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pgate_ff   <= PGATE_RST;
      pdiv_ff    <= PDIV_RST;
      vmap_ff    <= 1'b0;
      pll_ff     <= 2'h0;
      extmode_ff <= '0;
      extpol_ff  <= '0;
      wakeen_ff  <= '0;
      extsel_ff  <= '0;
      rtcsrc_ff  <= 1'b0;
    end else if (wr_stb) begin
      case (wb_adr_in)
        OFS_PGATE: pgate_ff <= PERIPH_N'(wmask({16'h0000, pgate_ff},
                                 wb_dat_in, wb_sel_in));
        OFS_PDIV: if (wb_sel_in[0]) pdiv_ff <= wb_dat_in[1:0];
        OFS_VMAP: if (wb_sel_in[0]) vmap_ff <= wb_dat_in[0];
        OFS_PLL: if (wb_sel_in[0]) pll_ff <= wb_dat_in[1:0];
        OFS_EXTMODE: extmode_ff <= EXT_N'(wmask({23'h0, extmode_ff},
                                   wb_dat_in, wb_sel_in));
        OFS_EXTPOL: extpol_ff <= EXT_N'(wmask({23'h0, extpol_ff},
                                 wb_dat_in, wb_sel_in));
        OFS_WAKEEN: wakeen_ff <= EXT_N'(wmask({23'h0, wakeen_ff},
                                 wb_dat_in, wb_sel_in));
        OFS_EXTSEL: extsel_ff <= (2*EXT_N)'(wmask({14'h0, extsel_ff},
                                 wb_dat_in, wb_sel_in));
        OFS_RTCSRC: if (wb_sel_in[0]) rtcsrc_ff <= wb_dat_in[0];
        default: ;
      endcase
    end
  end

  // Flags: write one to clear, new event wins over the clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      extflag_ff <= '0;
    end else begin
      extflag_ff <= (extflag_ff &
                     ~((wr_stb && wb_adr_in == OFS_EXTFLAG) ?
                       EXT_N'(wmask(32'h0, wb_dat_in, wb_sel_in)) :
                       '0)) | ext_event;
    end
  end

  // ****************************************************
  // Bus answer
  // ****************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wr_stb || rd_stb;
      if (rd_stb) begin
        case (wb_adr_in)
          OFS_MODE:    wb_dat_out <= {30'h0, mode_ff};
          OFS_PGATE:   wb_dat_out <= {16'h0, pgate_ff};
          OFS_PDIV:    wb_dat_out <= {30'h0, pdiv_ff};
          OFS_VMAP:    wb_dat_out <= {31'h0, vmap_ff};
          OFS_PLL:     wb_dat_out <= {30'h0, pll_ff};
          OFS_EXTMODE: wb_dat_out <= {23'h0, extmode_ff};
          OFS_EXTPOL:  wb_dat_out <= {23'h0, extpol_ff};
          OFS_EXTFLAG: wb_dat_out <= {23'h0, extflag_ff};
          OFS_WAKEEN:  wb_dat_out <= {23'h0, wakeen_ff};
          OFS_EXTSEL:  wb_dat_out <= {14'h0, extsel_ff};
          OFS_RTCSRC:  wb_dat_out <= {31'h0, rtcsrc_ff};
          OFS_STATUS:  wb_dat_out <= {30'h0, state_ff};
          default:     wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************
  // Clock gating outputs
  // ****************************************************
  logic pclk_tick;

  pclk_divider u_pdiv (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .run_in   (state_ff != ST_PDOWN),
    .sel_in   (pdiv_ff),
    .tick_out (pclk_tick)
  );

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cpu_clock_en_out        <= 1'b1;
      mem_bus_clk_en_out      <= 1'b1;
      osc_en_out              <= 1'b1;
      pll_en_out              <= 1'b0;
      pll_connect_out         <= 1'b0;
      peripheral_bus_tick_out <= 1'b0;
      periph_clk_en_out       <= '0;
      rtc_ext_clk_out         <= 1'b0;
      vec_map_ram_out         <= 1'b0;
      irq_out                 <= '0;
      pin_hold_out            <= 1'b0;
    end else begin
      cpu_clock_en_out   <= (state_ff == ST_RUN);
      mem_bus_clk_en_out <= (state_ff == ST_RUN);
      osc_en_out         <= (state_ff != ST_PDOWN);
      // Pll follows software in idle, off only in power-down
      pll_en_out      <= pll_ff[BIT_PLL_EN] &&
                         (state_ff != ST_PDOWN);
      pll_connect_out <= pll_ff[BIT_PLL_EN] && pll_ff[BIT_PLL_CON] &&
                         (state_ff != ST_PDOWN);
      peripheral_bus_tick_out <= pclk_tick;
      periph_clk_en_out <= (state_ff == ST_PDOWN) ?
                           '0 : pgate_ff;
      rtc_ext_clk_out <= rtcsrc_ff;
      vec_map_ram_out <= vmap_ff;
      irq_out         <= nxt_irq;
      pin_hold_out    <= (state_ff == ST_PDOWN);
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  chk_idle_stop: assert property (
    state_ff == ST_IDLE |=> !cpu_clock_en_out)
    else $error("cpu clock running in idle");
  chk_pd_osc: assert property (
    state_ff == ST_PDOWN |=> !osc_en_out && periph_clk_en_out == '0)
    else $error("clocks alive in power-down");
  chk_pd_hold: assert property (
    state_ff == ST_PDOWN |=> pin_hold_out)
    else $error("pins not held");
  chk_wake_timer: assert property (
    state_ff == ST_PDOWN && pd_wake |=> state_ff == ST_WAKE)
    else $error("wake skipped timer");
  chk_idle_wake: assert property (
    state_ff == ST_IDLE && any_irq |=> state_ff == ST_RUN ##1 cpu_clock_en_out)
    else $error("idle not ended by irq");
  chk_mode_clear: assert property (
    state_ff == ST_WAKE && wake_done |=> mode_ff == 2'h0)
    else $error("mode not cleared");
  chk_pll_idle: assert property (
    state_ff == ST_IDLE && pll_ff[BIT_PLL_EN] |=> pll_en_out)
    else $error("pll dropped in idle");
  chk_wake_gate: assert property (
    state_ff == ST_PDOWN && !pd_wake |=> state_ff == ST_PDOWN)
    else $error("unenabled wake");
  cov_idle: cover property (@(posedge clk_in) state_ff == ST_IDLE);
  cov_pdown: cover property (@(posedge clk_in)
    state_ff == ST_WAKE ##1 state_ff == ST_RUN);
  cov_irq: cover property (@(posedge clk_in) irq_out != '0);

endmodule

//--- testbench/test_power_mode_clock_control.sv
// Self-checking bench for the power mode and clock control block
`timescale 1ns/1ns
module test_power_mode_clock_control;
  import pwr_ctl_pkg::*;

  // ****************************************************
  // Signals and instance
  // ****************************************************
  localparam int unsigned WAKE_SIM = 8;
  logic                clk_in;
  logic                rst_b_in;
  logic                wb_cyc_in;
  logic                wb_stb_in;
  logic                wb_we_in;
  logic [7:0]          wb_adr_in;
  logic [3:0]          wb_sel_in;
  logic [31:0]         wb_dat_in;
  logic [31:0]         wb_dat_out;
  logic                wb_ack_out;
  logic [EXT_N-1:0]    ext_irq_in;
  logic                periph_irq_in;
  logic                cpu_clock_en_out;
  logic                mem_bus_clk_en_out;
  logic                osc_en_out;
  logic                pll_en_out;
  logic                pll_connect_out;
  logic                peripheral_bus_tick_out;
  logic [PERIPH_N-1:0] periph_clk_en_out;
  logic                rtc_ext_clk_out;
  logic                vec_map_ram_out;
  logic [IRQ_N-1:0]    irq_out;
  logic                pin_hold_out;
  int                  miscompares;
  int                  n_tests;

  power_mode_clock_control #(
    .WAKE_CNT (WAKE_SIM)
  ) power_mode_clock_control_inst (
    .clk_in                  (clk_in),
    .rst_b_in                (rst_b_in),
    .wb_cyc_in               (wb_cyc_in),
    .wb_stb_in               (wb_stb_in),
    .wb_we_in                (wb_we_in),
    .wb_adr_in               (wb_adr_in),
    .wb_sel_in               (wb_sel_in),
    .wb_dat_in               (wb_dat_in),
    .wb_dat_out              (wb_dat_out),
    .wb_ack_out              (wb_ack_out),
    .ext_irq_in              (ext_irq_in),
    .periph_irq_in           (periph_irq_in),
    .cpu_clock_en_out        (cpu_clock_en_out),
    .mem_bus_clk_en_out      (mem_bus_clk_en_out),
    .osc_en_out              (osc_en_out),
    .pll_en_out              (pll_en_out),
    .pll_connect_out         (pll_connect_out),
    .peripheral_bus_tick_out (peripheral_bus_tick_out),
    .periph_clk_en_out       (periph_clk_en_out),
    .rtc_ext_clk_out         (rtc_ext_clk_out),
    .vec_map_ram_out         (vec_map_ram_out),
    .irq_out                 (irq_out),
    .pin_hold_out            (pin_hold_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Holds the request until ack is sampled high, then releases it
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_dat_in <= wdat;
    wb_sel_in <= 4'hf;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) check_val("bus ack", 32'h1, 32'h0);
    rdat = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, adr, d, r);
  endtask

  task automatic wb_check(input string what, input logic [7:0] adr,
                          input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, adr, 32'h0, r);
    check_val(what, exp, r);
  endtask

  task automatic count_ticks(output int n);
    n = 0;
    repeat (16) begin
      @(posedge clk_in);
      if (peripheral_bus_tick_out === 1'b1) n++;
    end
  endtask

  // Bounded wait on the cpu clock enable (0) or oscillator enable (1)
  task automatic wait_en(input int which, output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (((which == 0) ? cpu_clock_en_out : osc_en_out) !== 1'b1
               && n < 100);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic test_reset();
    int n;
    // Divider and its output register need a few edges to settle
    repeat (4) @(posedge clk_in);
    count_ticks(n);
    check_val("tick count", 32'd4, n);
    check_val("pll outputs", 32'h0, {pll_en_out, pll_connect_out});
    check_val("periph enables", 32'hffff, periph_clk_en_out);
    wb_check("pdiv", OFS_PDIV, 32'h0);
    wb_check("pll reg", OFS_PLL, 32'h0);
    wb_check("pgate", OFS_PGATE, 32'hffff);
    wb_check("status", OFS_STATUS, 32'h0);
    wb_write(8'h40, 32'h5555_aaaa);
    wb_check("unmapped", 8'h40, 32'h0);
  endtask

  task automatic test_divider();
    int per [4] = '{4, 1, 2, 4};
    int n;
    for (int s = 3; s >= 0; s--) begin
      wb_write(OFS_PDIV, s);
      wb_check("pdiv", OFS_PDIV, s);
      count_ticks(n);
      check_val("tick count", 16 / per[s], n);
    end
  endtask

  task automatic test_gating();
    wb_write(OFS_PGATE, 32'h5a3c);
    repeat (2) @(posedge clk_in);
    check_val("periph enables", 32'h5a3c, periph_clk_en_out);
    wb_write(OFS_VMAP, 32'h1);
    repeat (2) @(posedge clk_in);
    check_val("vector map", 32'h1, vec_map_ram_out);
    wb_write(OFS_VMAP, 32'h0);
    repeat (2) @(posedge clk_in);
    check_val("vector map", 32'h0, vec_map_ram_out);
    wb_write(OFS_RTCSRC, 32'h1);
    wb_write(OFS_PLL, 32'h3);
  endtask

  task automatic test_ext_irq();
    logic [31:0] sel;
    sel = 32'h0;
    for (int j = 0; j < EXT_N; j++) sel[2*j +: 2] = j % 4;
    wb_write(OFS_EXTSEL, sel);
    wb_write(OFS_EXTPOL, 32'h1ff);
    wb_write(OFS_EXTMODE, 32'h0);
    wb_write(OFS_EXTFLAG, 32'h1ff);
    for (int j = 0; j < EXT_N; j++) begin
      ext_irq_in <= 9'h001 << j;
      repeat (6) @(posedge clk_in);
      check_val("irq lines", 32'h1 << (j % 4), irq_out);
      ext_irq_in <= 9'h000;
      repeat (4) @(posedge clk_in);
      wb_write(OFS_EXTFLAG, 32'h1ff);
      repeat (3) @(posedge clk_in);
      check_val("irq lines", 32'h0, irq_out);
    end
  endtask

  task automatic test_idle();
    int n;
    for (int k = 0; k < 2; k++) begin
      wb_write(OFS_MODE, 32'h1);
      repeat (3) @(posedge clk_in);
      check_val("cpu en", 32'h0, cpu_clock_en_out);
      check_val("mem bus en", 32'h0, mem_bus_clk_en_out);
      check_val("pll idle", 32'h3, {pll_en_out, pll_connect_out});
      check_val("periph idle", 32'h5a3c, periph_clk_en_out);
      count_ticks(n);
      check_val("idle ticks", 32'd4, n);
      if (k == 0) periph_irq_in <= 1'b1;
      else ext_irq_in <= 9'h004;
      wait_en(0, n);
      check_val("idle wake", 32'h1, n < 12);
      periph_irq_in <= 1'b0;
      ext_irq_in <= 9'h000;
      repeat (4) @(posedge clk_in);
      wb_check("mode cleared", OFS_MODE, 32'h0);
      wb_write(OFS_EXTFLAG, 32'h1ff);
    end
  endtask

  task automatic test_pdown();
    int n;
    wb_write(OFS_WAKEEN, 32'h1);
    wb_write(OFS_EXTMODE, 32'h1);
    wb_write(OFS_MODE, 32'h2);
    repeat (3) @(posedge clk_in);
    check_val("osc en", 32'h0, osc_en_out);
    check_val("cpu mem en", 32'h0,
              {cpu_clock_en_out, mem_bus_clk_en_out});
    check_val("pll off", 32'h0, {pll_en_out, pll_connect_out});
    check_val("periph off", 32'h0, periph_clk_en_out);
    check_val("pin hold", 32'h1, pin_hold_out);
    check_val("rtc source", 32'h1, rtc_ext_clk_out);
    count_ticks(n);
    check_val("pdown ticks", 32'd0, n);
    // Input not enabled for wake must leave the chip asleep
    ext_irq_in <= 9'h002;
    repeat (20) @(posedge clk_in);
    check_val("osc asleep", 32'h0, osc_en_out);
    ext_irq_in <= 9'h003;
    wait_en(1, n);
    check_val("osc wake", 32'h1, n < 12);
    wait_en(0, n);
    check_val("settle wait", 32'h1, n >= WAKE_SIM && n < 40);
    repeat (3) @(posedge clk_in);
    check_val("pin release", 32'h0, pin_hold_out);
    check_val("periph back", 32'h5a3c, periph_clk_en_out);
    ext_irq_in <= 9'h000;
    wb_check("mode cleared", OFS_MODE, 32'h0);
    wb_check("pll kept", OFS_PLL, 32'h3);
    wb_check("status run", OFS_STATUS, 32'h0);
  endtask

  // ****************************************************
  // Sequence and verdict
  // ****************************************************
  task automatic finish_test();
    $display("checks %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    miscompares = 0;
    n_tests = 0;
    rst_b_in = 1'b0;
    {wb_cyc_in, wb_stb_in, wb_we_in, periph_irq_in} = 4'h0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    ext_irq_in = 9'h000;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    test_reset();
    test_divider();
    test_gating();
    test_ext_irq();
    test_idle();
    test_pdown();
    finish_test();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge clk_in);
    miscompares++;
    finish_test();
  end

endmodule
